// ---- bench/iso_link_chk.sv ----
/*
  concurrent checks on the link between controller and device ends.
  assumes one clock and a synchronous active-high reset on both ends.
*/
`timescale 1ns/10ps

module iso_link_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req,
  input wire logic we,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack,
  input wire logic host_line_oe,
  input wire logic fault_line
);
  // ****************************************************************
  // link walk
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence take_s;
    req && !ack;
  endsequence
  sequence done_s;
    ack ##1 (!ack && !req);
  endsequence

  ack_walk_a: assert property (take_s |=> done_s)
    else $error("link answer not one cycle after request");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("link ack longer than one cycle");
  req_hold_a: assert property (
    take_s |=> $stable(we) && $stable(addr) && $stable(wdata))
    else $error("request changed before ack");
  ack_cause_a: assert property (ack |-> req && $past(req))
    else $error("ack without held request");
  rdata_hold_a: assert property (!ack |-> $stable(rdata))
    else $error("read data moved outside an answer");
  idle_ack_a: assert property (!req |-> !ack)
    else $error("ack while idle");
  req_gap_a: assert property ($rose(req) |-> !ack && !$past(ack))
    else $error("request restarted during answer");
  host_pull_a: assert property (!host_line_oe |-> !fault_line)
    else $error("fault line high while pulled");

  walk_c: cover property (take_s ##1 ack);
endmodule : iso_link_chk

// ---- bench/isolation_fault_action_control_tb_top.sv ----
/*
  testbench for the controller and device ends joined by the link.
  assumes the wishbone side is the only way in for software.
*/
`timescale 1ns/10ps
`include "iso_params.svh"

module isolation_fault_action_control_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic we_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic ack_o;
  logic pos_oc = 1'b0, neg_oc = 1'b0, pos_uv = 1'b0, neg_uv = 1'b0;
  logic bgl = 1'b0, rgl = 1'b0, safe = 1'b1;
  logic bridge_g, rev_g;
  logic [2:0] phase_g;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  iso_link_if iso_link_if_inst ();
  // short watchdog so its timeout fits the run
  iso_device #(.WDOG_CYCLES(50)) iso_device_inst (.clk_i(clk_i),
    .rst_i(rst_i), .link(iso_link_if_inst), .positive_overcurrent_i(pos_oc),
    .negative_overcurrent_i(neg_oc), .positive_undervoltage_i(pos_uv),
    .negative_undervoltage_i(neg_uv), .bridge_gate_low_i(bgl),
    .reverse_gate_low_i(rgl), .reverse_current_safe_i(safe),
    .bridge_supply_gate_o(bridge_g), .reverse_battery_gate_o(rev_g),
    .phase_gate_o(phase_g));
  iso_host iso_host_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .link(iso_link_if_inst));
  iso_link_chk iso_link_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
    .req(iso_link_if_inst.req), .we(iso_link_if_inst.we),
    .addr(iso_link_if_inst.addr), .wdata(iso_link_if_inst.wdata),
    .rdata(iso_link_if_inst.rdata), .ack(iso_link_if_inst.ack),
    .host_line_oe(iso_link_if_inst.host_line_oe),
    .fault_line(iso_link_if_inst.fault_line));

  // ****************************************************************
  // clock, timeout, report
  // ****************************************************************
  always #50 clk_i = ~clk_i;

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    // the whole run needs well under a thousand cycles
    if (cycles == 3000) begin
      num_errors++;
      end_of_test;
    end
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // held until ack; a hang is cut by the cycle ceiling
  task wb(input logic [3:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'h3;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  task dev(input logic [3:0] i, input logic w, input logic [15:0] v,
    output logic [15:0] r);
    logic [31:0] d;
    if (w) begin
      wb(`HREG_WDATA, 1'b1, {16'h0, v}, d);
    end
    wb(`HREG_CMD, 1'b1, {23'h0, w, 4'h0, i}, d);
    do wb(`HREG_STAT, 1'b0, 32'h0, d); while (d[0] !== 1'b0);
    wb(`HREG_RDATA, 1'b0, 32'h0, d);
    r = d[15:0];
  endtask : dev

  task wr(input logic [3:0] i, input logic [15:0] v);
    logic [15:0] r;
    dev(i, 1'b1, v, r);
  endtask : wr

  task rd(input string n, input logic [3:0] i, input logic [15:0] e);
    logic [15:0] r;
    dev(i, 1'b0, 16'h0, r);
    chk(n, e, r);
  endtask : rd

  task gchk(input logic [15:0] e);
    chk("gates", e, {11'h0, phase_g, rev_g, bridge_g});
  endtask : gchk

  task trig(input int t, input logic v);
    logic [31:0] d;
    case (t)
      0: pos_oc <= v;
      1: neg_oc <= v;
      2: pos_uv <= v;
      3: neg_uv <= v;
      default: wb(`HREG_STAT, 1'b1, {29'h0, v, 2'h0}, d);
    endcase
  endtask : trig

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    logic [31:0] d;
    logic [2:0] p;
    logic [15:0] e;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl", `REG_CTRL, `CTRL_RESET);
    rd("action", `REG_ACTION, `ACTION_RESET);
    rd("unmapped index", 4'h3, 16'h0000);
    wb(4'h2, 1'b0, 32'h0, d);
    chk("unmapped wb", 16'h0000, d[15:0]);
    repeat (60) @(posedge clk_i);
    wb(`HREG_STAT, 1'b0, 32'h0, d);
    chk("line", 16'h0002, d[15:0]);
    rd("wdog", `REG_STATUS, 16'h0020);
    wr(`REG_CTRL, 16'h0005);
    gchk(16'h0000);
    wr(`REG_CTRL, 16'h0400);
    rd("ctrl", `REG_CTRL, 16'h0400);
    wr(`REG_STATUS, 16'h00FF);
    rd("status", `REG_STATUS, 16'h0000);
    $display("test reset and watchdog done");
    wr(`REG_CTRL, 16'h0475);
    gchk(16'h001F);
    pos_uv <= 1'b1;
    bgl <= 1'b1;
    rgl <= 1'b1;
    repeat (8) @(posedge clk_i);
    gchk(16'h001F);
    rd("status", `REG_STATUS, 16'h1FC4);
    pos_uv <= 1'b0;
    bgl <= 1'b0;
    rgl <= 1'b0;
    repeat (8) @(posedge clk_i);
    wr(`REG_STATUS, 16'h00FF);
    wr(`REG_CTRL, 16'h0474);
    gchk(16'h001E);
    wr(`REG_CTRL, 16'h0470);
    gchk(16'h001C);
    $display("test plain drive done");
    // bit 15 is reserved and must read back clear
    wr(`REG_ACTION, 16'hFA8F);
    rd("action", `REG_ACTION, 16'h7A8F);
    for (int t = 0; t < `NUM_TRIG; t++) begin
      e = 16'h7A8F;
      p = e[3*t +: 3];
      e = (16'h1 << t) | 16'h1C00 | {2'b0, p[2], 3'b0, ~p[1], ~p[0], 8'h0};
      wr(`REG_CTRL, 16'h0475);
      trig(t, 1'b1);
      repeat (8) @(posedge clk_i);
      gchk({11'h0, 3'h7, ~p[1], ~p[0]});
      rd("status", `REG_STATUS, e);
      trig(t, 1'b0);
      repeat (8) @(posedge clk_i);
      wr(`REG_STATUS, 16'h00FF);
      gchk({11'h0, 3'h7, ~p[1], ~p[0]});
    end
    $display("test trigger table done");
    wr(`REG_ACTION, 16'h0002);
    wr(`REG_CTRL, 16'h1400);
    wr(`REG_CTRL, 16'h1475);
    safe <= 1'b0;
    trig(0, 1'b1);
    repeat (8) @(posedge clk_i);
    gchk(16'h001F);
    safe <= 1'b1;
    repeat (8) @(posedge clk_i);
    gchk(16'h001D);
    $display("test current qualified done");
    // positive overcurrent still latched: phase latch now holds
    wr(`REG_ACTION, 16'h0004);
    wr(`REG_CTRL, 16'h0780);
    wr(`REG_CTRL, 16'h0470);
    gchk(16'h0000);
    // gate undervoltage must not flag while the drivers are off
    bgl <= 1'b1;
    rgl <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd("status", `REG_STATUS, 16'h2001);
    bgl <= 1'b0;
    rgl <= 1'b0;
    trig(0, 1'b0);
    repeat (8) @(posedge clk_i);
    wr(`REG_STATUS, 16'h00FF);
    wr(`REG_CTRL, 16'h0470);
    gchk(16'h001C);
    $display("test phase latch done");
    end_of_test;
  end
endmodule : isolation_fault_action_control_tb_top

// ---- logic/iso_device.sv ----
/*
  device end: gate enables for bridge-supply, reverse-battery and phase
  drivers, fault latches, fault actions, watchdog and the fault line.
  assumes comparator and current levels arrive asynchronously and the
  controller keeps one request held until it sees ack.
*/
`timescale 1ns/10ps
`include "iso_params.svh"

// Contract
// - current check gates automatic reverse turn-off
// - host arms triggers, then qualification, then on
// - bridge undervoltages may trip bridge and reverse
// - phases never tripped; latched off during fault
// - three action bits for positive undervoltage
// - three action bits for negative undervoltage
// - fault line pulled low is a fault
// - three action bits for fault-line trigger
// - any selected trigger turns driver off
// - no actions: bridge follows requests only
// - no actions: reverse follows requests only
// - bridge on: on one, off zero, one write
// - bridge off: on request zero, one write
// - reverse on: on one, off zero, one write
// - phase on: on one, off zero
// - flag bridge gate undervoltage while on
// - flag reverse gate undervoltage while on
// - watchdog on at reset, default timeout
// - pump enable resets zero, needed for gates
// - all action bits reset to zero
// - write one clears a latched fault
// - three action bits for positive overcurrent
// - host disables watchdog, reads back, clears
module iso_device
  import iso_pkg::*;
#(
  parameter int WDOG_CYCLES = `WDOG_TIMEOUT_MS * `CLK_KHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  iso_link_if.device link,
  input wire logic positive_overcurrent_i,
  input wire logic negative_overcurrent_i,
  input wire logic positive_undervoltage_i,
  input wire logic negative_undervoltage_i,
  input wire logic bridge_gate_low_i,
  input wire logic reverse_gate_low_i,
  input wire logic reverse_current_safe_i,
  output logic bridge_supply_gate_o,
  output logic reverse_battery_gate_o,
  output logic [2:0] phase_gate_o
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // one action column across all triggers
  function automatic logic [`NUM_TRIG-1:0] column(
    input logic [15:0] act,
    input int col
  );
    logic [`NUM_TRIG-1:0] r;
    r = '0;
    for (int t = 0; t < `NUM_TRIG; t++) begin
      r[t] = act[t*3+col];
    end
    return r;
  endfunction : column

  // ****************************************************************
  // input synchronisation
  // ****************************************************************
  logic [7:0] raw;
  logic [7:0] sy;
  logic pos_oc;
  logic neg_oc;
  logic pos_uv;
  logic neg_uv;
  logic bridge_glow;
  logic reverse_glow;
  logic rev_safe;
  logic line_low;

  assign raw = {~link.fault_line, reverse_current_safe_i, reverse_gate_low_i,
                bridge_gate_low_i, negative_undervoltage_i,
                positive_undervoltage_i, negative_overcurrent_i,
                positive_overcurrent_i};

  sync2 #(
    .WIDTH(8)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(raw),
    .q_o(sy)
  );

  assign pos_oc = sy[0];
  assign neg_oc = sy[1];
  assign pos_uv = sy[2];
  assign neg_uv = sy[3];
  assign bridge_glow = sy[4];
  assign reverse_glow = sy[5];
  assign rev_safe = sy[6];
  assign line_low = sy[7];

  // ****************************************************************
  // state
  // ****************************************************************
  dev_state_t s_q;
  dev_state_t s_d;
  logic [`NUM_TRIG-1:0] trig;
  logic bridge_trip;
  logic reverse_trip;
  logic phase_latch;

  // triggers act from the latched faults, so a trip outlives the event
  assign trig = s_q.fault[`NUM_TRIG-1:0];
  assign bridge_trip = |(trig & column(s_q.action, `ACT_BRIDGE));
  // qualification adds a current condition to reverse turn-off
  assign reverse_trip = (|(trig & column(s_q.action, `ACT_REVERSE))) &
                        (~s_q.ctrl[`CTRL_CURRENT_QUAL] | rev_safe);
  assign phase_latch = |(trig & column(s_q.action, `ACT_PHASE));

  always_comb begin
    logic [7:0] set;
    logic [7:0] clr;
    logic wr;
    logic bon;
    logic boff;
    logic ron;
    logic roff;
    logic [2:0] pon;
    logic [2:0] poff;
    s_d = s_q;
    set = '0;
    clr = '0;
    wr = 1'b0;
    bon = 1'b0;
    boff = 1'b0;
    ron = 1'b0;
    roff = 1'b0;
    pon = '0;
    poff = '0;
    s_d.ack = 1'b0;

    // ---- register access, one per held request
    if (link.req && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.wdog_cnt = '0;
      wr = link.we;
      if (link.addr == `REG_CTRL) begin
        s_d.rdata = s_q.ctrl;
        if (wr) begin
          s_d.ctrl = link.wdata;
          // on with off clear in the same write turns a driver on
          bon = link.wdata[`CTRL_BRIDGE_ON] &
                ~link.wdata[`CTRL_BRIDGE_OFF];
          boff = ~link.wdata[`CTRL_BRIDGE_ON];
          ron = link.wdata[`CTRL_REVERSE_ON] &
                ~link.wdata[`CTRL_REVERSE_OFF];
          roff = ~link.wdata[`CTRL_REVERSE_ON];
          pon = link.wdata[`CTRL_PHASE_ON +: 3] &
                ~link.wdata[`CTRL_PHASE_OFF +: 3];
          poff = ~link.wdata[`CTRL_PHASE_ON +: 3];
        end
      end else if (link.addr == `REG_ACTION) begin
        s_d.rdata = s_q.action;
        if (wr) begin
          s_d.action = {1'b0, link.wdata[14:0]};
        end
      end else if (link.addr == `REG_STATUS) begin
        s_d.rdata = {2'b00, phase_latch, s_q.phase_on, s_q.reverse_on,
                     s_q.bridge_on, s_q.fault};
        if (wr) begin
          clr = link.wdata[7:0];
        end
      end else begin
        s_d.rdata = '0;
      end
    end

    // ---- fault capture, set beats clear
    set[`ST_POS_OC] = pos_oc;
    set[`ST_NEG_OC] = neg_oc;
    set[`ST_POS_UV] = pos_uv;
    set[`ST_NEG_UV] = neg_uv;
    // own pull-down is ignored, including its synchroniser tail
    set[`ST_EXT] = line_low & ~s_q.drive_low & ~|s_q.drive_hist;
    set[`ST_BRIDGE_GUV] = s_q.bridge_on & bridge_glow;
    set[`ST_REVERSE_GUV] = s_q.reverse_on & reverse_glow;

    // ---- watchdog, restarted by every access
    if (!s_q.ctrl[`CTRL_WATCHDOG_ON]) begin
      s_d.wdog_cnt = '0;
    end else if (s_q.wdog_cnt == 24'(WDOG_CYCLES - 1)) begin
      set[`ST_WDOG] = 1'b1;
      s_d.wdog_cnt = '0;
    end else if (!(link.req && !s_q.ack)) begin
      s_d.wdog_cnt = s_q.wdog_cnt + 24'h000001;
    end
    s_d.fault = (s_q.fault & ~clr) | set;

    // ---- bridge-supply driver
    // only a new request re-arms it after a trip, never the fault clear
    if (bridge_trip || !s_q.ctrl[`CTRL_PUMP_ON]) begin
      s_d.bridge_on = 1'b0;
    end else if (bon) begin
      s_d.bridge_on = 1'b1;
    end else if (boff) begin
      s_d.bridge_on = 1'b0;
    end

    // ---- reverse-battery driver
    if (reverse_trip || !s_q.ctrl[`CTRL_PUMP_ON]) begin
      s_d.reverse_on = 1'b0;
    end else if (ron) begin
      s_d.reverse_on = 1'b1;
    end else if (roff) begin
      s_d.reverse_on = 1'b0;
    end

    // ---- phase drivers: the phase latch turns none off, it only stops off ones turning on
    for (int p = 0; p < 3; p++) begin
      if (!s_q.ctrl[`CTRL_PUMP_ON]) begin
        s_d.phase_on[p] = 1'b0;
      end else if (pon[p] && !phase_latch) begin
        s_d.phase_on[p] = 1'b1;
      end else if (poff[p]) begin
        s_d.phase_on[p] = 1'b0;
      end
    end

    // ---- fault line: pull low on latched watchdog or comparator faults
    s_d.drive_low = |{s_q.fault[`ST_WDOG], s_q.fault[3:0]};
    s_d.drive_hist = {s_q.drive_hist[1:0], s_q.drive_low};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{
        ctrl: `CTRL_RESET,
        action: `ACTION_RESET,
        fault: `FAULT_RESET,
        bridge_on: 1'b0,
        reverse_on: 1'b0,
        phase_on: 3'h0,
        ack: 1'b0,
        rdata: 16'h0000,
        wdog_cnt: 24'h000000,
        drive_low: 1'b0,
        drive_hist: 3'h0
      };
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign link.ack = s_q.ack;
  assign link.rdata = s_q.rdata;
  assign link.dev_line_o = 1'b0;
  assign link.dev_line_oe = ~s_q.drive_low;
  assign bridge_supply_gate_o = s_q.bridge_on;
  assign reverse_battery_gate_o = s_q.reverse_on;
  assign phase_gate_o = s_q.phase_on;

endmodule : iso_device

// ---- logic/iso_host.sv ----
/*
  controller end: a wishbone slave whose command register relays single
  register accesses to the device, and a pull bit for the fault line.
  assumes a classic wishbone master holding each request until ack.
*/
`timescale 1ns/10ps
`include "iso_params.svh"

module iso_host
  import iso_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  iso_link_if.host link
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction : merge

  logic line_low;
  host_state_t s_q;
  host_state_t s_d;

  sync2 #(
    .WIDTH(1)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(~link.fault_line),
    .q_o(line_low)
  );

  // ****************************************************************
  // bus slave and relay
  // ****************************************************************
  always_comb begin
    logic take;
    logic [15:0] cmd;
    s_d = s_q;
    take = cyc_i & stb_i & ~s_q.wb_ack;
    cmd = '0;
    s_d.wb_ack = take;
    if (take) begin
      if (adr_i == `HREG_CMD) begin
        s_d.wb_dat = {23'h00000, s_q.we, 4'h0, s_q.addr};
        // commands while busy are dropped; poll busy first
        if (we_i && s_q.st == H_IDLE) begin
          cmd = merge(16'h0000, dat_i, sel_i);
          s_d.addr = cmd[3:0];
          s_d.we = cmd[`HCMD_WE];
          // the whole data word goes in one access
          s_d.st = H_BUSY;
        end
      end else if (adr_i == `HREG_WDATA) begin
        s_d.wb_dat = {16'h0000, s_q.wdata};
        if (we_i) begin
          s_d.wdata = merge(s_q.wdata, dat_i, sel_i);
        end
      end else if (adr_i == `HREG_RDATA) begin
        s_d.wb_dat = {16'h0000, s_q.rdata};
      end else if (adr_i == `HREG_STAT) begin
        s_d.wb_dat = {29'h0000000, s_q.pull, line_low, s_q.st == H_BUSY};
        if (we_i && sel_i[0]) begin
          s_d.pull = dat_i[2];
        end
      end else begin
        s_d.wb_dat = '0;
      end
    end
    case (s_q.st)
      H_IDLE: begin
      end
      H_BUSY: begin
        if (link.ack) begin
          s_d.rdata = link.rdata;
          s_d.st = H_IDLE;
        end
      end
      default: begin
        s_d.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{
        st: H_IDLE,
        addr: 4'h0,
        we: 1'b0,
        wdata: 16'h0000,
        rdata: 16'h0000,
        pull: 1'b0,
        wb_ack: 1'b0,
        wb_dat: 32'h00000000
      };
    end else begin
      s_q <= s_d;
    end
  end

  assign ack_o = s_q.wb_ack;
  assign dat_o = s_q.wb_dat;
  assign link.req = (s_q.st == H_BUSY);
  assign link.we = s_q.we;
  assign link.addr = s_q.addr;
  assign link.wdata = s_q.wdata;
  assign link.host_line_o = 1'b0;
  assign link.host_line_oe = ~s_q.pull;

endmodule : iso_host

// ---- logic/iso_link_if.sv ----
/*
  link between controller and device: a held request with one-cycle
  acknowledge, plus the shared open-drain fault line.
  assumes both ends run on the same clock.
*/
`timescale 1ns/10ps

interface iso_link_if;
  logic req;
  logic we;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  logic dev_line_o;
  logic dev_line_oe;
  logic host_line_o;
  logic host_line_oe;
  logic fault_line;

  // wired-and: an end pulls low while its enable is low
  assign fault_line = (dev_line_oe | dev_line_o) & (host_line_oe | host_line_o);

  modport device (
    input req, we, addr, wdata, fault_line,
    output rdata, ack, dev_line_o, dev_line_oe
  );
  modport host (
    output req, we, addr, wdata, host_line_o, host_line_oe,
    input rdata, ack, fault_line
  );
endinterface : iso_link_if

// ---- logic/iso_params.svh ----
/*
  constants of the isolation fault-action pair: register indices, field
  positions, reset values and timing figures.
  assumes inclusion by bare name from the package and the design modules.
*/
`ifndef ISO_PARAMS_SVH
`define ISO_PARAMS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CLK_KHZ 10000
`define WDOG_TIMEOUT_MS 1310

// ****************************************************************
// device registers, reached as indices over the link
// ****************************************************************
`define REG_CTRL 4'h0
`define REG_ACTION 4'h1
`define REG_STATUS 4'h2

`define CTRL_BRIDGE_ON 0
`define CTRL_BRIDGE_OFF 1
`define CTRL_REVERSE_ON 2
`define CTRL_REVERSE_OFF 3
`define CTRL_PHASE_ON 4
`define CTRL_PHASE_OFF 7
`define CTRL_PUMP_ON 10
`define CTRL_WATCHDOG_ON 11
`define CTRL_CURRENT_QUAL 12
`define CTRL_RESET 16'h0800
`define ACTION_RESET 16'h0000

// action column within each three-bit trigger group
`define ACT_BRIDGE 0
`define ACT_REVERSE 1
`define ACT_PHASE 2
`define NUM_TRIG 5

// status bits; 7:0 are sticky and cleared by writing one
`define ST_POS_OC 0
`define ST_NEG_OC 1
`define ST_POS_UV 2
`define ST_NEG_UV 3
`define ST_EXT 4
`define ST_WDOG 5
`define ST_BRIDGE_GUV 6
`define ST_REVERSE_GUV 7
`define ST_BRIDGE_GATE 8
`define ST_REVERSE_GATE 9
`define ST_PHASE_GATE 10
`define ST_PHASE_LATCH 13
`define FAULT_RESET 8'h00

// ****************************************************************
// controller registers on the wishbone side (byte addresses)
// ****************************************************************
`define HREG_CMD 4'h0
`define HREG_WDATA 4'h4
`define HREG_RDATA 4'h8
`define HREG_STAT 4'hC
`define HCMD_WE 8

`endif

// ---- logic/iso_pkg.sv ----
/*
  types shared by the device end and the controller end.
  assumes iso_params.svh is on the include path.
*/
`include "iso_params.svh"

package iso_pkg;

  typedef enum logic [0:0] {
    H_IDLE = 1'b0,
    H_BUSY = 1'b1
  } hstate_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] action;
    logic [7:0] fault;
    logic bridge_on;
    logic reverse_on;
    logic [2:0] phase_on;
    logic ack;
    logic [15:0] rdata;
    logic [23:0] wdog_cnt;
    logic drive_low;
    logic [2:0] drive_hist;
  } dev_state_t;

  typedef struct packed {
    hstate_t st;
    logic [3:0] addr;
    logic we;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic pull;
    logic wb_ack;
    logic [31:0] wb_dat;
  } host_state_t;

endpackage : iso_pkg

// ---- logic/sync2.sv ----
/*
  two-flop synchroniser for a vector of independent levels.
  assumes each bit is a slow level; no word coherence is given.
*/
`timescale 1ns/10ps

module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : sync2
